// >>> logic/bwd_pkg.sv
// Purpose: Shared constants and carrier types for the bus watchdog.
// Assumes: Registers sit on byte offsets within a 4 KB APB window.
// Notes:   Identification values are module parameters, not held here.

package bwd_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned BWD_AW = 12;
  localparam int unsigned BWD_DW = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] BWD_OFF_RELOAD = 12'h000;
  localparam logic [11:0] BWD_OFF_VALUE = 12'h004;
  localparam logic [11:0] BWD_OFF_CONTROL = 12'h008;
  localparam logic [11:0] BWD_OFF_INTCLEAR = 12'h00C;
  localparam logic [11:0] BWD_OFF_RAWSTAT = 12'h010;
  localparam logic [11:0] BWD_OFF_MASKSTAT = 12'h014;
  localparam logic [11:0] BWD_OFF_LOCK = 12'hC00;
  localparam logic [11:0] BWD_OFF_ITCTRL = 12'hF00;
  localparam logic [11:0] BWD_OFF_ITOUT = 12'hF04;
  localparam logic [11:0] BWD_OFF_ID4 = 12'hFD0;
  localparam logic [11:0] BWD_OFF_ID0 = 12'hFE0;
  localparam logic [11:0] BWD_OFF_ID1 = 12'hFE4;
  localparam logic [11:0] BWD_OFF_ID2 = 12'hFE8;
  localparam logic [11:0] BWD_OFF_ID3 = 12'hFEC;
  localparam logic [11:0] BWD_OFF_CID0 = 12'hFF0;
  localparam logic [11:0] BWD_OFF_CID1 = 12'hFF4;
  localparam logic [11:0] BWD_OFF_CID2 = 12'hFF8;
  localparam logic [11:0] BWD_OFF_CID3 = 12'hFFC;

  // ----------------------------------------------------------------
  // Field positions, key and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BWD_CTRL_COUNTER_INTERRUPT_ENABLE_BIT = 0;
  localparam int unsigned BWD_CTRL_RESET_OUTPUT_ENABLE_BIT = 1;
  localparam int unsigned BWD_ITOP_RES_BIT = 0;
  localparam int unsigned BWD_ITOP_INT_BIT = 1;
  localparam int unsigned BWD_ITCR_MODE_BIT = 0;
  localparam int unsigned BWD_REV_LSB = 4;
  localparam logic [31:0] BWD_UNLOCK_KEY = 32'h1ACCE551;
  localparam logic [31:0] BWD_RELOAD_RST = 32'hFFFFFFFF;
  localparam logic [1:0] BWD_CONTROL_RST = 2'h0;
  localparam logic [1:0] BWD_ITOUT_RST = 2'h0;
  localparam logic BWD_LOCK_RST = 1'b0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } bwd_apb_req_t;

  typedef struct packed {
    logic reset_output_enable;
    logic counter_interrupt_enable;
  } bwd_ctrl_t;

endpackage : bwd_pkg

// >>> logic/bwd_counter.sv
// Purpose: Down-counter with interrupt and timeout request for the watchdog.
// Assumes: Count clock equals the bus clock; i_clk_en marks count edges.
// Notes:   Reload requests act at once, independent of the clock enable.

module bwd_counter #(
  parameter int unsigned CW = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_dom_rst_n,
  input wire logic i_count_en,
  input wire logic i_clk_en,
  input wire logic i_reload,
  input wire logic [CW-1:0] i_reload_value,
  input wire logic i_irq_clear,
  output logic [CW-1:0] o_count,
  output logic o_raw_irq,
  output logic o_reset_req
);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic irq_q;
  logic irq_d;
  logic req_q;
  logic req_d;
  logic tick;
  logic zero_hit;

  // ----------------------------------------------------------------
  // Next-state terms
  // ----------------------------------------------------------------
  assign tick = i_count_en & i_clk_en & i_dom_rst_n; // [R02] [R14]
  // Reload request masks the zero event of the same edge
  assign zero_hit = tick & ~i_reload & (count_q == '0);
  assign count_d = !i_dom_rst_n ? {CW{1'b1}} : // [R20]
                   i_reload ? i_reload_value : // [R03] [R04] [R17]
                   zero_hit ? i_reload_value : // [R18]
                   tick ? count_q - {{(CW-1){1'b0}}, 1'b1} :
                   count_q;
  // Set beats clear so a zero event is never lost
  assign irq_d = !i_dom_rst_n ? 1'b0 :
                 zero_hit ? 1'b1 :
                 i_irq_clear ? 1'b0 : irq_q; // [R04]
  // Second zero with interrupt still pending raises timeout
  assign req_d = !i_dom_rst_n ? 1'b0 :
                 (zero_hit & irq_q) ? 1'b1 : req_q; // [R19]

  // State registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count_q <= {CW{1'b1}};
      irq_q <= 1'b0;
      req_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      irq_q <= irq_d;
      req_q <= req_d;
    end
  end

  assign o_count = count_q;
  assign o_raw_irq = irq_q; // [R05]
  assign o_reset_req = req_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  cnt_dec_a: assert property ( // [R14]
    tick && !i_reload && count_q != '0 |=> count_q == $past(count_q) - 1)
    else $error("counter did not decrement");
  cnt_hold_a: assert property ( // [R02]
    i_dom_rst_n && !i_reload && !(i_count_en && i_clk_en) |=> $stable(count_q))
    else $error("counter moved without enable");
  zero_reload_a: assert property ( // [R18]
    zero_hit |=> count_q == $past(i_reload_value) && o_raw_irq)
    else $error("zero did not reload and raise interrupt");
  timeout_req_a: assert property ( // [R19]
    zero_hit && irq_q |=> o_reset_req)
    else $error("second zero did not request reset");
  reload_now_a: assert property ( // [R17]
    i_reload && i_dom_rst_n |=> count_q == $past(i_reload_value))
    else $error("reload request not honoured");
  dom_reset_a: assert property ( // [R20]
    !i_dom_rst_n |=> !o_raw_irq && !o_reset_req ##0 count_q == {CW{1'b1}})
    else $error("domain reset did not clear counter state");

endmodule : bwd_counter

// >>> logic/bwd_watchdog.sv
// Purpose: Register file, lock and test logic of an APB watchdog.
// Assumes: Count clock is the bus clock; count enable marks count edges.
// Notes:   APB slave with zero wait states and no error response.
//
// How it works
// R01 - Control bit 1 masks timeout reset output
// R02 - Control bit 0 enables counter and interrupt
// R03 - Enable rising edge reloads counter
// R04 - Clear write drops interrupt, reloads counter
// R05 - Raw status bit 0 is unmasked interrupt
// R06 - Masked status equals raw AND enable; drives pin
// R07 - Key unlocks writes; other values relock
// R08 - Locked: only lock register accepts writes
// R09 - Lock read: bit 0 status, rest zero
// R10 - Unlocked after reset
// R11 - Test control bit 0 enters test mode
// R12 - Test mode: pins follow test output bits
// R13 - Unused upper register bits read zero
// R14 - Count only on enabled clock edges
// R15 - System supplies count clock synchronous to bus
// R16 - Revision input feeds identification register
// R17 - Reload register write restarts countdown
// R18 - After zero, reload and keep counting
// R19 - Uncleared interrupt at next zero requests reset
// R20 - Domain reset clears counter, interrupt, outputs (the code loads all ones into the counter)

module bwd_watchdog #(
  parameter int unsigned CW = 32,
  // Identification bytes: arbitrary neutral values
  parameter logic [7:0] ID4_VAL = 8'h00,
  parameter logic [7:0] ID0_VAL = 8'h11,
  parameter logic [7:0] ID1_VAL = 8'h22,
  parameter logic [7:0] ID2_VAL = 8'h33,
  parameter logic [3:0] ID3_LOW_VAL = 4'h0,
  parameter logic [7:0] CID0_VAL = 8'h44,
  parameter logic [7:0] CID1_VAL = 8'h55,
  parameter logic [7:0] CID2_VAL = 8'h66,
  parameter logic [7:0] CID3_VAL = 8'h77
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_count_clock_enable,
  input wire logic i_count_domain_reset_n,
  input wire logic [3:0] i_late_revision_input,
  output logic o_timeout_irq_out,
  output logic o_timeout_reset_out
);

  // ----------------------------------------------------------------
  // Bus request carrier
  // ----------------------------------------------------------------
  bwd_pkg::bwd_apb_req_t req;
  assign req.sel = i_psel;
  assign req.enable = i_penable;
  assign req.write = i_pwrite;
  assign req.addr = i_paddr;
  assign req.wdata = i_pwdata;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] reload_q;
  logic [31:0] reload_d;
  bwd_pkg::bwd_ctrl_t ctrl_q;
  bwd_pkg::bwd_ctrl_t ctrl_d;
  logic lock_q;
  logic lock_d;
  logic itcr_q;
  logic itcr_d;
  logic [1:0] itop_q;
  logic [1:0] itop_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic wr_access;
  logic rd_setup;
  logic wr_open;
  logic wr_lock;
  logic wr_reload;
  logic wr_ctrl;
  logic wr_intclr;
  logic wr_itcr;
  logic wr_itop;
  logic en_rise;
  logic cnt_reload;
  logic [CW-1:0] cnt_value;
  logic [CW-1:0] cnt_reload_value;
  logic [CW-1:0] count;
  logic raw_irq;
  logic reset_req;
  logic masked_irq;
  logic [31:0] rd_mux;
  logic [31:0] id_mux;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Writes commit in the access phase; reads are fetched in setup
  assign wr_access = req.sel & req.enable & req.write;
  assign rd_setup = req.sel & ~req.enable & ~req.write;
  // Lock gates every write except to the lock register itself
  assign wr_open = wr_access & ~lock_q; // [R08]
  assign wr_lock = wr_access & (req.addr == bwd_pkg::BWD_OFF_LOCK); // [R07]
  assign wr_reload = wr_open & (req.addr == bwd_pkg::BWD_OFF_RELOAD);
  assign wr_ctrl = wr_open & (req.addr == bwd_pkg::BWD_OFF_CONTROL);
  assign wr_intclr = wr_open & (req.addr == bwd_pkg::BWD_OFF_INTCLEAR);
  assign wr_itcr = wr_open & (req.addr == bwd_pkg::BWD_OFF_ITCTRL);
  assign wr_itop = wr_open & (req.addr == bwd_pkg::BWD_OFF_ITOUT);

  // Zero wait states, no error response
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  assign reload_d = wr_reload ? req.wdata : reload_q;
  assign ctrl_d = wr_ctrl ?
    {req.wdata[bwd_pkg::BWD_CTRL_RESET_OUTPUT_ENABLE_BIT],
     req.wdata[bwd_pkg::BWD_CTRL_COUNTER_INTERRUPT_ENABLE_BIT]} : ctrl_q;
  // Only the exact key opens; anything else closes
  assign lock_d = wr_lock ? (req.wdata != bwd_pkg::BWD_UNLOCK_KEY)
                          : lock_q; // [R07]
  assign itcr_d = wr_itcr ?
    req.wdata[bwd_pkg::BWD_ITCR_MODE_BIT] : itcr_q; // [R11]
  assign itop_d = wr_itop ?
    {req.wdata[bwd_pkg::BWD_ITOP_INT_BIT],
     req.wdata[bwd_pkg::BWD_ITOP_RES_BIT]} : itop_q;

  // Software registers
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      reload_q <= bwd_pkg::BWD_RELOAD_RST;
      ctrl_q <= bwd_pkg::BWD_CONTROL_RST;
      lock_q <= bwd_pkg::BWD_LOCK_RST; // [R10]
      itcr_q <= 1'b0;
      itop_q <= bwd_pkg::BWD_ITOUT_RST;
    end
    else
    begin
      reload_q <= reload_d;
      ctrl_q <= ctrl_d;
      lock_q <= lock_d;
      itcr_q <= itcr_d;
      itop_q <= itop_d;
    end
  end

  // ----------------------------------------------------------------
  // Counter control
  // ----------------------------------------------------------------
  // Enable rising from software restarts the countdown
  assign en_rise = ctrl_d.counter_interrupt_enable &
                   ~ctrl_q.counter_interrupt_enable; // [R03]
  assign cnt_reload = en_rise | wr_intclr | wr_reload; // [R04] [R17]
  // A fresh reload write takes the new value in the same cycle
  assign cnt_reload_value = reload_d[CW-1:0];

  bwd_counter #(
    .CW(CW)
  ) u_counter (
    .i_clk(i_core_clk),
    .i_rst(i_rst),
    .i_dom_rst_n(i_count_domain_reset_n),
    .i_count_en(ctrl_q.counter_interrupt_enable),
    .i_clk_en(i_count_clock_enable),
    .i_reload(cnt_reload),
    .i_reload_value(cnt_reload_value),
    .i_irq_clear(wr_intclr),
    .o_count(count),
    .o_raw_irq(raw_irq),
    .o_reset_req(reset_req)
  );
  assign cnt_value = count;

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  assign masked_irq = raw_irq & ctrl_q.counter_interrupt_enable; // [R06]
  // Test mode hands both pins straight to the test output bits
  assign o_timeout_irq_out = itcr_q ?
    itop_q[bwd_pkg::BWD_ITOP_INT_BIT] : masked_irq; // [R06] [R12]
  assign o_timeout_reset_out = itcr_q ?
    itop_q[bwd_pkg::BWD_ITOP_RES_BIT] :
    (reset_req & ctrl_q.reset_output_enable); // [R01] [R12]

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Identification window; revision nibble is a live input
  assign id_mux =
    (req.addr == bwd_pkg::BWD_OFF_ID4) ? {24'h000000, ID4_VAL} :
    (req.addr == bwd_pkg::BWD_OFF_ID0) ? {24'h000000, ID0_VAL} :
    (req.addr == bwd_pkg::BWD_OFF_ID1) ? {24'h000000, ID1_VAL} :
    (req.addr == bwd_pkg::BWD_OFF_ID2) ? {24'h000000, ID2_VAL} :
    (req.addr == bwd_pkg::BWD_OFF_ID3) ?
      {24'h000000, i_late_revision_input, ID3_LOW_VAL} : // [R16]
    (req.addr == bwd_pkg::BWD_OFF_CID0) ? {24'h000000, CID0_VAL} :
    (req.addr == bwd_pkg::BWD_OFF_CID1) ? {24'h000000, CID1_VAL} :
    (req.addr == bwd_pkg::BWD_OFF_CID2) ? {24'h000000, CID2_VAL} :
    (req.addr == bwd_pkg::BWD_OFF_CID3) ? {24'h000000, CID3_VAL} :
    32'h00000000;

  // Narrow registers pad with zeros; unmapped reads give zero
  assign rd_mux =
    (req.addr == bwd_pkg::BWD_OFF_RELOAD) ? reload_q :
    (req.addr == bwd_pkg::BWD_OFF_VALUE) ?
      32'(cnt_value) :
    (req.addr == bwd_pkg::BWD_OFF_CONTROL) ?
      {30'h00000000, ctrl_q} : // [R13]
    (req.addr == bwd_pkg::BWD_OFF_RAWSTAT) ?
      {31'h00000000, raw_irq} : // [R05] [R13]
    (req.addr == bwd_pkg::BWD_OFF_MASKSTAT) ?
      {31'h00000000, masked_irq} : // [R06] [R13]
    (req.addr == bwd_pkg::BWD_OFF_LOCK) ?
      {31'h00000000, lock_q} : // [R09]
    (req.addr == bwd_pkg::BWD_OFF_ITCTRL) ?
      {31'h00000000, itcr_q} : // [R13]
    id_mux;

  assign prdata_d = rd_setup ? rd_mux : prdata_q;

  // Read data register, valid through the access phase
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prdata_q <= 32'h00000000;
    end
    else
    begin
      prdata_q <= prdata_d;
    end
  end

  assign o_prdata = prdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  lock_key_a: assert property ( // [R07]
    wr_lock |=> lock_q == ($past(req.wdata) != bwd_pkg::BWD_UNLOCK_KEY))
    else $error("lock state wrong after lock write");
  locked_ignore_a: assert property ( // [R08]
    wr_access && lock_q && req.addr != bwd_pkg::BWD_OFF_LOCK
    |=> $stable(ctrl_q) && $stable(reload_q) && $stable(itcr_q))
    else $error("locked write changed a register");
  lock_read_a: assert property ( // [R09]
    rd_setup && req.addr == bwd_pkg::BWD_OFF_LOCK
    |=> o_prdata == {31'h00000000, lock_q})
    else $error("lock read returned wrong value");
  irq_mask_a: assert property ( // [R06]
    !itcr_q |-> o_timeout_irq_out ==
      (raw_irq && ctrl_q.counter_interrupt_enable))
    else $error("interrupt pin not masked raw status");
  reset_gate_a: assert property ( // [R01]
    !itcr_q && !ctrl_q.reset_output_enable |-> !o_timeout_reset_out)
    else $error("reset output active while masked");
  test_pins_a: assert property ( // [R12]
    itcr_q |-> o_timeout_irq_out == itop_q[1] &&
      o_timeout_reset_out == itop_q[0])
    else $error("test mode pins do not follow test output");
  int_clear_a: assert property ( // [R04]
    wr_intclr && i_count_domain_reset_n
    |=> !raw_irq && cnt_value == $past(reload_q[CW-1:0]))
    else $error("clear did not drop interrupt and reload");
  en_reload_a: assert property ( // [R03]
    en_rise && !wr_reload && i_count_domain_reset_n
    |=> cnt_value == $past(reload_q[CW-1:0]))
    else $error("enable edge did not reload counter");
  ctrl_read_a: assert property ( // [R13]
    rd_setup && req.addr == bwd_pkg::BWD_OFF_CONTROL
    |=> o_prdata[31:2] == 30'h00000000)
    else $error("control upper bits not zero");

  // Status, test control and identification read-back
  raw_read_a: assert property ( // [R05]
    rd_setup && req.addr == bwd_pkg::BWD_OFF_RAWSTAT
    |=> o_prdata == {31'h00000000, $past(raw_irq)})
    else $error("raw status read returned wrong value");
  mask_read_a: assert property ( // [R06]
    rd_setup && req.addr == bwd_pkg::BWD_OFF_MASKSTAT
    |=> o_prdata == {31'h00000000,
      $past(raw_irq && ctrl_q.counter_interrupt_enable)})
    else $error("masked status read returned wrong value");
  itcr_read_a: assert property ( // [R13]
    rd_setup && req.addr == bwd_pkg::BWD_OFF_ITCTRL
    |=> o_prdata[31:1] == 31'h00000000)
    else $error("test control upper bits not zero");
  rev_read_a: assert property ( // [R16]
    rd_setup && req.addr == bwd_pkg::BWD_OFF_ID3
    |=> o_prdata[bwd_pkg::BWD_REV_LSB +: 4] == $past(i_late_revision_input))
    else $error("revision field does not follow input");

  // Write paths and reset state
  unlock_rst_a: assert property ( // [R10]
    $past(i_rst) |-> !lock_q)
    else $error("block not unlocked after reset");
  itcr_write_a: assert property ( // [R11]
    wr_itcr |=> itcr_q == $past(req.wdata[bwd_pkg::BWD_ITCR_MODE_BIT]))
    else $error("test control write did not land");
  itop_write_a: assert property ( // [R12]
    wr_itop |=> itop_q == $past(req.wdata[1:0]))
    else $error("test output write did not land");
  reload_write_a: assert property ( // [R17]
    wr_reload && i_count_domain_reset_n
    |=> reload_q == $past(req.wdata) &&
      cnt_value == $past(req.wdata[CW-1:0]))
    else $error("reload write did not restart countdown");
  ctrl_write_a: assert property ( // [R07]
    wr_access && !lock_q && req.addr == bwd_pkg::BWD_OFF_CONTROL
    |=> ctrl_q == $past(req.wdata[1:0]))
    else $error("unlocked control write did not land");
  lock_stays_a: assert property ( // [R08]
    wr_access && lock_q && req.addr != bwd_pkg::BWD_OFF_LOCK
    |=> lock_q)
    else $error("locked write released the lock");

  // Pin gating outside test mode
  reset_follow_a: assert property ( // [R01]
    !itcr_q && ctrl_q.reset_output_enable
    |-> o_timeout_reset_out == reset_req)
    else $error("enabled reset output does not follow request");
  mask_off_a: assert property ( // [R02]
    !itcr_q && !ctrl_q.counter_interrupt_enable |-> !o_timeout_irq_out)
    else $error("interrupt pin active while disabled");

  irq_seen_c: cover property (!itcr_q ##1 $rose(o_timeout_irq_out));
  timeout_seen_c: cover property (!itcr_q ##1 $rose(o_timeout_reset_out));
  relock_c: cover property (!lock_q ##1 lock_q ##[1:20] !lock_q);
  test_mode_c: cover property (itcr_q && o_timeout_reset_out);
  locked_write_c: cover property (wr_access && lock_q);

endmodule : bwd_watchdog

// >>> test/bwd_host_model.sv
// Purpose: Bus master model that speaks APB to the watchdog registers.
// Assumes: Count clock is the bus clock, so one clock serves both sides.
// Notes:   Released address and data show the inverse of the last value.

module bwd_host_model (
  input wire logic i_core_clk,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  output bwd_pkg::bwd_apb_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------------------------
  initial
  begin
    o_req = '0;
  end

  // One transfer: setup, access held until ready, then release
  // Runs on the bus clock, which also paces counting
  task automatic apb_xfer(input logic wr, input logic [11:0] addr,
                          input logic [31:0] wdata,
                          output logic [31:0] rdata);
    int n;
    bwd_pkg::bwd_apb_req_t idle;
    n = 0;
    @(posedge i_core_clk);
    o_req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: addr,
               wdata: wdata};
    @(posedge i_core_clk);
    o_req.enable <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 16);
    rdata = i_prdata;
    // Stale values inverted so a late sample cannot pass by luck
    idle = '{sel: 1'b0, enable: 1'b0, write: wr, addr: ~addr,
             wdata: ~wdata};
    o_req <= idle;
  endtask : apb_xfer
endmodule : bwd_host_model

// >>> test/bwd_watchdog_bench.sv
// Purpose: Self-checking bench for the watchdog register block.
// Assumes: Zero-wait APB; count strobe held high for runs of an exact number of enabled edges.
// Notes:   Count strobe stays low during bus cycles so counts are exact.

module bwd_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0] REV = 4'hA;
  localparam logic [3:0] ID3_LOW = 4'h3;
  logic clk;
  logic rst;
  logic cen;
  logic drst_n;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic tmo;
  bwd_pkg::bwd_apb_req_t req;
  int n_mismatch;
  int total_checks;
  int cycles;

  // ----------------------------------------------------------------
  // Design and bus master
  // ----------------------------------------------------------------
  bwd_watchdog #(.ID3_LOW_VAL(ID3_LOW)) i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_psel(req.sel),
    .i_penable(req.enable), .i_pwrite(req.write), .i_paddr(req.addr),
    .i_pwdata(req.wdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_count_clock_enable(cen),
    .i_count_domain_reset_n(drst_n), .i_late_revision_input(REV),
    .o_timeout_irq_out(irq), .o_timeout_reset_out(tmo));

  bwd_host_model i_host (
    .i_core_clk(clk), .i_prdata(prdata), .i_pready(pready), .o_req(req));

  // Clock at 25 ns, and a hang guard well past the test length
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    logic [31:0] dummy;
    i_host.apb_xfer(1'b1, addr, data, dummy);
    check("slave_error", {31'h0, pslverr}, 32'h0);
  endtask : wr

  task automatic rd(input string name, input logic [11:0] addr,
                    input logic [31:0] exp);
    logic [31:0] data;
    i_host.apb_xfer(1'b0, addr, 32'h0, data);
    check(name, data, exp);
  endtask : rd

  // Exactly k enabled count edges, strobe low again afterwards
  task automatic pulse(input int k);
    repeat (k)
    begin
      @(posedge clk);
      cen <= 1'b1;
    end
    @(posedge clk);
    cen <= 1'b0;
    #1;
  endtask : pulse

  task automatic pins(input logic e_irq, input logic e_tmo);
    #1;
    check("irq_pin", {31'h0, irq}, {31'h0, e_irq});
    check("reset_pin", {31'h0, tmo}, {31'h0, e_tmo});
  endtask : pins

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    cen = 1'b0;
    drst_n = 1'b1;
    cycles = 0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset state and unmapped space
    rd("reload", bwd_pkg::BWD_OFF_RELOAD, 32'hFFFFFFFF);
    rd("control", bwd_pkg::BWD_OFF_CONTROL, 32'h00000000);
    rd("lock", bwd_pkg::BWD_OFF_LOCK, 32'h00000000);
    rd("unmapped", 12'h100, 32'h00000000);
    rd("id3", bwd_pkg::BWD_OFF_ID3, {24'h0, REV, ID3_LOW});
    // Reload write restarts, disabled counter holds
    wr(bwd_pkg::BWD_OFF_RELOAD, 32'h00000003);
    rd("value", bwd_pkg::BWD_OFF_VALUE, 32'h00000003);
    pulse(2);
    rd("value_off", bwd_pkg::BWD_OFF_VALUE, 32'h00000003);
    wr(bwd_pkg::BWD_OFF_CONTROL, 32'h00000001);
    repeat (4) @(posedge clk);
    rd("value_noen", bwd_pkg::BWD_OFF_VALUE, 32'h00000003);
    pulse(3);
    rd("value_zero", bwd_pkg::BWD_OFF_VALUE, 32'h00000000);
    rd("raw_before", bwd_pkg::BWD_OFF_RAWSTAT, 32'h00000000);
    pulse(1);
    pins(1'b1, 1'b0);
    rd("value_wrap", bwd_pkg::BWD_OFF_VALUE, 32'h00000003);
    rd("masked", bwd_pkg::BWD_OFF_MASKSTAT, 32'h00000001);
    // Disabled: pin masked, raw kept, re-enable reloads count
    wr(bwd_pkg::BWD_OFF_CONTROL, 32'h00000000);
    pins(1'b0, 1'b0);
    rd("raw_off", bwd_pkg::BWD_OFF_RAWSTAT, 32'h00000001);
    rd("masked_off", bwd_pkg::BWD_OFF_MASKSTAT, 32'h00000000);
    pulse(1);
    wr(bwd_pkg::BWD_OFF_RELOAD, 32'h00000002);
    pulse(1);
    wr(bwd_pkg::BWD_OFF_CONTROL, 32'h00000003);
    rd("value_reen", bwd_pkg::BWD_OFF_VALUE, 32'h00000002);
    rd("control3", bwd_pkg::BWD_OFF_CONTROL, 32'h00000003);
    // Second zero with interrupt still pending: timeout
    pulse(2);
    pins(1'b1, 1'b0);
    pulse(1);
    pins(1'b1, 1'b1);
    wr(bwd_pkg::BWD_OFF_CONTROL, 32'h00000001);
    pins(1'b1, 1'b0);
    pulse(1);
    wr(bwd_pkg::BWD_OFF_INTCLEAR, 32'h5A5A5A5A);
    pins(1'b0, 1'b0);
    rd("raw_clr", bwd_pkg::BWD_OFF_RAWSTAT, 32'h00000000);
    rd("value_clr", bwd_pkg::BWD_OFF_VALUE, 32'h00000002);
    // Lock: wrong key locks, writes ignored, key unlocks
    wr(bwd_pkg::BWD_OFF_LOCK, 32'h1ACCE550);
    rd("locked", bwd_pkg::BWD_OFF_LOCK, 32'h00000001);
    wr(bwd_pkg::BWD_OFF_RELOAD, 32'h00000007);
    wr(bwd_pkg::BWD_OFF_CONTROL, 32'h00000000);
    rd("reload_lk", bwd_pkg::BWD_OFF_RELOAD, 32'h00000002);
    rd("control_lk", bwd_pkg::BWD_OFF_CONTROL, 32'h00000001);
    wr(bwd_pkg::BWD_OFF_LOCK, bwd_pkg::BWD_UNLOCK_KEY);
    rd("unlocked", bwd_pkg::BWD_OFF_LOCK, 32'h00000000);
    // Test mode drives pins from the test output bits
    wr(bwd_pkg::BWD_OFF_ITCTRL, 32'hFFFFFFFF);
    rd("itctrl", bwd_pkg::BWD_OFF_ITCTRL, 32'h00000001);
    wr(bwd_pkg::BWD_OFF_ITOUT, 32'h00000002);
    pins(1'b1, 1'b0);
    wr(bwd_pkg::BWD_OFF_ITOUT, 32'h00000001);
    pins(1'b0, 1'b1);
    rd("itout", bwd_pkg::BWD_OFF_ITOUT, 32'h00000000);
    wr(bwd_pkg::BWD_OFF_ITCTRL, 32'h00000000);
    // Count-domain reset loads all ones into the count and clears pending events
    wr(bwd_pkg::BWD_OFF_CONTROL, 32'h00000003);
    pulse(3);
    @(posedge clk);
    drst_n <= 1'b0;
    @(posedge clk);
    drst_n <= 1'b1;
    pins(1'b0, 1'b0);
    rd("raw_drst", bwd_pkg::BWD_OFF_RAWSTAT, 32'h00000000);
    rd("value_drst", bwd_pkg::BWD_OFF_VALUE, 32'hFFFFFFFF);
    report_and_stop();
  end
endmodule : bwd_watchdog_bench
